/* src/oamd_operand_addr_decoder.sv */
// Operand and addressing-mode decoder: effective-address offset,
// segment choice, register operands, direction and immediate value.
// Assumes fetch presents the specifier, scale byte, offset and immediate
// together with valid_i, and the register file values on gpr_i.
`timescale 1ns/1ps
`default_nettype none

module oamd_operand_addr_decoder
#(
   parameter int unsigned DATA_W = 32,
   parameter int unsigned GPR_N  = 8
)
(
   input  wire logic                    clk_i,
   input  wire logic                    arst_n_i,
   input  wire logic                    valid_i,
   input  wire logic                    addr32_i,
   input  wire logic                    op32_i,
   input  wire logic                    size_flag_i,
   input  wire logic                    dir_flag_i,
   input  wire logic                    sign_ext_i,
   input  wire logic [1:0]              imm_size_i,
   input  wire logic [7:0]              specifier_i,
   input  wire logic [7:0]              scale_byte_i,
   input  wire logic [31:0]             offset_i,
   input  wire logic [31:0]             imm_i,
   input  wire logic [GPR_N*DATA_W-1:0] gpr_i,
   output logic                         valid_o,
   output logic                         sib_expected_o,
   output logic                         mem_operand_o,
   output logic                         addr_supported_o,
   output logic [31:0]                  ea_offset_o,
   output logic                         stack_segment_o,
   output logic [1:0]                   offset_kind_o,
   output logic                         base_used_o,
   output logic                         index_used_o,
   output logic [2:0]                   sel_reg_idx_o,
   output logic [1:0]                   sel_width_o,
   output logic                         sel_high_o,
   output logic [2:0]                   fld_reg_idx_o,
   output logic [1:0]                   fld_width_o,
   output logic                         fld_high_o,
   output logic                         dst_is_field_o,
   output logic                         src_is_field_o,
   output logic [31:0]                  imm_value_o
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   // Address arithmetic is written for 32-bit words and 3-bit codes
   generate
      if (DATA_W != 32 || GPR_N != 8)
      begin : g_bad_param
         $error("oamd: DATA_W must be 32 and GPR_N must be 8");
      end
   endgenerate

   // ------------------------------------------------------------
   // Functions
   // ------------------------------------------------------------
   // Sign-extend a byte to a full word
   function automatic logic [31:0] sext8(input logic [7:0] b);
      sext8 = {{24{b[7]}}, b};
   endfunction

   // Read general register n from the flattened file
   function automatic logic [31:0] gpr_read(input logic [GPR_N*DATA_W-1:0] f,
                                            input logic [2:0]              n);
      gpr_read = f[n*DATA_W +: 32];
   endfunction

   // Offset size implied by the addressing form
   function automatic oamd_pkg::oamd_offset_t form_offset(input logic [1:0] f);
      form_offset = oamd_pkg::OAMD_OFS_NONE;
      if (f == oamd_pkg::FORM_SHORT_OFFSET)
      begin
         form_offset = oamd_pkg::OAMD_OFS_SHORT;
      end
      else if (f == oamd_pkg::FORM_LONG_OFFSET)
      begin
         form_offset = oamd_pkg::OAMD_OFS_LONG;
      end
   endfunction

   // ------------------------------------------------------------
   // Field extraction
   // ------------------------------------------------------------
   logic [1:0] form;
   logic [2:0] field_code;
   logic [2:0] sel_code;
   logic [1:0] scale;
   logic [2:0] index_code;
   logic [2:0] base_code;

   // Form, field and selector from the specifier, the rest from the scale byte
   assign form       = specifier_i[oamd_pkg::FORM_MSB:oamd_pkg::FORM_LSB];
   assign field_code = specifier_i[oamd_pkg::FIELD_MSB:oamd_pkg::FIELD_LSB];
   assign sel_code   = specifier_i[oamd_pkg::SEL_MSB:oamd_pkg::SEL_LSB];
   assign scale      = scale_byte_i[oamd_pkg::SCALE_MSB:oamd_pkg::SCALE_LSB];
   assign index_code = scale_byte_i[oamd_pkg::INDEX_MSB:oamd_pkg::INDEX_LSB];
   assign base_code  = scale_byte_i[oamd_pkg::BASE_MSB:oamd_pkg::BASE_LSB];

   // ------------------------------------------------------------
   // Addressing decode
   // ------------------------------------------------------------
   logic                  is_mem;
   logic                  sib_needed;
   logic                  base_en;
   logic                  index_en;
   logic                  stack_seg;
   logic [2:0]            base_sel;
   oamd_pkg::oamd_offset_t ofs_kind;

   assign is_mem     = (form != oamd_pkg::FORM_REGISTER);
   // Scale byte only under 32-bit addressing with a memory form
   assign sib_needed = addr32_i && is_mem
                       && (sel_code == oamd_pkg::SEL_SCALE_BYTE);

   // Which terms join the sum and which segment is the default
   always_comb
   begin
      base_en   = 1'b0;
      index_en  = 1'b0;
      stack_seg = 1'b0;
      base_sel  = sel_code;
      ofs_kind  = oamd_pkg::OAMD_OFS_NONE;
      if (!is_mem || !addr32_i)
      begin
         // Register operand or unsupported 16-bit addressing
         base_en = 1'b0;
      end
      else if (!sib_needed)
      begin
         if (form == oamd_pkg::FORM_NO_OFFSET && sel_code == oamd_pkg::SEL_LONG_ONLY)
         begin
            ofs_kind = oamd_pkg::OAMD_OFS_LONG;
         end
         else
         begin
            base_en   = 1'b1;
            ofs_kind  = form_offset(form);
            stack_seg = (sel_code == oamd_pkg::BASE_BASE_PTR);
         end
      end
      else
      begin
         base_sel = base_code;
         index_en = (index_code != oamd_pkg::INDEX_NONE);
         if (form == oamd_pkg::FORM_NO_OFFSET && base_code == oamd_pkg::BASE_BASE_PTR)
         begin
            // Long offset stands in for the base, data segment
            ofs_kind = oamd_pkg::OAMD_OFS_LONG;
         end
         else
         begin
            base_en   = 1'b1;
            ofs_kind  = form_offset(form);
            stack_seg = (base_code == oamd_pkg::BASE_STACK_PTR)
                        || (base_code == oamd_pkg::BASE_BASE_PTR);
         end
      end
   end

   // ------------------------------------------------------------
   // Offset arithmetic
   // ------------------------------------------------------------
   logic [31:0] base_term;
   logic [31:0] index_term;
   logic [31:0] ofs_term;
   logic [31:0] ea_sum;

   assign base_term = base_en ? gpr_read(gpr_i, base_sel) : 32'h0000_0000;

   // Index shifted by the scale code; with no index the term is zero.
   // A nonzero scale with no index is the supplier's fault and gives zero.
   assign index_term = index_en ? (gpr_read(gpr_i, index_code) << scale)
                                : 32'h0000_0000;

   // Short offset taken from the low byte and widened with its sign
   always_comb
   begin
      ofs_term = 32'h0000_0000;
      unique case (ofs_kind)
         oamd_pkg::OAMD_OFS_NONE:  ofs_term = 32'h0000_0000;
         oamd_pkg::OAMD_OFS_SHORT: ofs_term = sext8(offset_i[7:0]);
         oamd_pkg::OAMD_OFS_LONG:  ofs_term = offset_i;
         default:                  ofs_term = 32'h0000_0000;
      endcase
   end

   // Carries out of bit 31 are dropped: offsets wrap in the segment
   assign ea_sum = base_term + index_term + ofs_term;

   // ------------------------------------------------------------
   // Register operand selection
   // ------------------------------------------------------------
   oamd_pkg::oamd_width_t sel_width;
   oamd_pkg::oamd_width_t fld_width;
   logic [2:0]            sel_idx;
   logic [2:0]            fld_idx;
   logic                  sel_high;
   logic                  fld_high;

   // Selector names a register only in the register form
   oamd_reg_select u_sel_select
   (
      .code_i      (1'b0),
      .code_bits_i (sel_code),
      .size_flag_i (size_flag_i),
      .op32_i      (op32_i),
      .width_o     (sel_width),
      .reg_idx_o   (sel_idx),
      .high_byte_o (sel_high)
   );

   oamd_reg_select u_fld_select
   (
      .code_i      (1'b1),
      .code_bits_i (field_code),
      .size_flag_i (size_flag_i),
      .op32_i      (op32_i),
      .width_o     (fld_width),
      .reg_idx_o   (fld_idx),
      .high_byte_o (fld_high)
   );

   // ------------------------------------------------------------
   // Immediate formation
   // ------------------------------------------------------------
   logic [31:0] imm_value;

   // Extension only for a byte immediate into a word or dword target
   always_comb
   begin
      imm_value = 32'h0000_0000;
      unique case (oamd_pkg::oamd_imm_t'(imm_size_i))
         oamd_pkg::OAMD_IMM_8:
         begin
            if (sign_ext_i && size_flag_i)
            begin
               imm_value = op32_i ? sext8(imm_i[7:0])
                                  : {16'h0000, {8{imm_i[7]}}, imm_i[7:0]};
            end
            else
            begin
               imm_value = {24'h00_0000, imm_i[7:0]};
            end
         end
         oamd_pkg::OAMD_IMM_16: imm_value = {16'h0000, imm_i[15:0]};
         oamd_pkg::OAMD_IMM_32: imm_value = imm_i;
         default:               imm_value = 32'h0000_0000;
      endcase
   end

   // ------------------------------------------------------------
   // Output stage
   // ------------------------------------------------------------
   // Decode result is valid one edge after valid_i
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         valid_o <= oamd_pkg::RST_BIT;
      end
      else
      begin
         valid_o <= valid_i;
      end
   end

   // Address group; held while valid_i is low so consumers see no glitch
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sib_expected_o   <= oamd_pkg::RST_BIT;
         mem_operand_o    <= oamd_pkg::RST_BIT;
         addr_supported_o <= oamd_pkg::RST_BIT;
         ea_offset_o      <= oamd_pkg::RST_WORD;
         stack_segment_o  <= oamd_pkg::RST_BIT;
         offset_kind_o    <= oamd_pkg::OAMD_OFS_NONE;
         base_used_o      <= oamd_pkg::RST_BIT;
         index_used_o     <= oamd_pkg::RST_BIT;
      end
      else if (valid_i)
      begin
         sib_expected_o   <= sib_needed;
         mem_operand_o    <= is_mem;
         addr_supported_o <= addr32_i || !is_mem;
         ea_offset_o      <= ea_sum;
         stack_segment_o  <= stack_seg;
         offset_kind_o    <= ofs_kind;
         base_used_o      <= base_en;
         index_used_o     <= index_en;
      end
   end

   // Register operand group
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         sel_reg_idx_o <= oamd_pkg::RST_IDX;
         sel_width_o   <= oamd_pkg::OAMD_W_BYTE;
         sel_high_o    <= oamd_pkg::RST_BIT;
         fld_reg_idx_o <= oamd_pkg::RST_IDX;
         fld_width_o   <= oamd_pkg::OAMD_W_BYTE;
         fld_high_o    <= oamd_pkg::RST_BIT;
      end
      else if (valid_i)
      begin
         sel_reg_idx_o <= sel_idx;
         sel_width_o   <= sel_width;
         sel_high_o    <= sel_high;
         fld_reg_idx_o <= fld_idx;
         fld_width_o   <= fld_width;
         fld_high_o    <= fld_high;
      end
   end

   // Direction and immediate group
   always_ff @(posedge clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         dst_is_field_o <= oamd_pkg::RST_BIT;
         src_is_field_o <= oamd_pkg::RST_BIT;
         imm_value_o    <= oamd_pkg::RST_WORD;
      end
      else if (valid_i)
      begin
         dst_is_field_o <= dir_flag_i;
         src_is_field_o <= !dir_flag_i;
         imm_value_o    <= imm_value;
      end
   end

endmodule

`default_nettype wire

/* src/oamd_pkg.sv */
// Constants, field layouts and code enumerations for the operand and
// addressing-mode decoder.
// Assumes a 32-bit core with eight general registers indexed 0 to 7.
//
// Operation
// - Form 00: register n, or bare long offset
// - Forms 01/10 add short/long offset, 101 stack
// - Form 11: register operand, 32-bit data widths
// - 16-bit data: word registers, same byte mapping
// - Scale byte, form 00: base plus scaled index
// - Scale byte forms 01/10: offset, stack bases
// - Scale code multiplies index by 1,2,4,8
// - Index code 100 adds no index term
// - Form from specifier; scale/index/base from scale byte
// - Direction 0: register field is source
// - Direction 1: register field is destination
// - Sign-extend 8-bit immediate into wider destination
// - Sign-extend bit ignored for wider immediates
// - Scale byte expected: selector 100, form not 11 (code also requires addr32_i)
package oamd_pkg;

   // ------------------------------------------------------------
   // Field positions in the operand specifier and scale bytes
   // ------------------------------------------------------------
   localparam int unsigned FORM_MSB  = 7;
   localparam int unsigned FORM_LSB  = 6;
   localparam int unsigned FIELD_MSB = 5;
   localparam int unsigned FIELD_LSB = 3;
   localparam int unsigned SEL_MSB   = 2;
   localparam int unsigned SEL_LSB   = 0;
   localparam int unsigned SCALE_MSB = 7;
   localparam int unsigned SCALE_LSB = 6;
   localparam int unsigned INDEX_MSB = 5;
   localparam int unsigned INDEX_LSB = 3;
   localparam int unsigned BASE_MSB  = 2;
   localparam int unsigned BASE_LSB  = 0;

   // ------------------------------------------------------------
   // Addressing form and selector codes
   // ------------------------------------------------------------
   localparam logic [1:0] FORM_NO_OFFSET    = 2'h0;
   localparam logic [1:0] FORM_SHORT_OFFSET = 2'h1;
   localparam logic [1:0] FORM_LONG_OFFSET  = 2'h2;
   localparam logic [1:0] FORM_REGISTER     = 2'h3;
   localparam logic [2:0] SEL_SCALE_BYTE    = 3'h4;
   localparam logic [2:0] SEL_LONG_ONLY     = 3'h5;
   localparam logic [2:0] BASE_STACK_PTR    = 3'h4;
   localparam logic [2:0] BASE_BASE_PTR     = 3'h5;
   localparam logic [2:0] INDEX_NONE        = 3'h4;
   localparam logic [2:0] BYTE_HIGH_FIRST   = 3'h4;

   // ------------------------------------------------------------
   // Reset values of the output stage
   // ------------------------------------------------------------
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [2:0]  RST_IDX  = 3'h0;
   localparam logic        RST_BIT  = 1'b0;

   // ------------------------------------------------------------
   // Enumerations
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      OAMD_OFS_NONE  = 2'b00,
      OAMD_OFS_SHORT = 2'b01,
      OAMD_OFS_LONG  = 2'b10
   } oamd_offset_t;

   typedef enum logic [1:0]
   {
      OAMD_W_BYTE  = 2'b00,
      OAMD_W_WORD  = 2'b01,
      OAMD_W_DWORD = 2'b10
   } oamd_width_t;

   typedef enum logic [1:0]
   {
      OAMD_IMM_8  = 2'b00,
      OAMD_IMM_16 = 2'b01,
      OAMD_IMM_32 = 2'b10
   } oamd_imm_t;

endpackage

/* src/oamd_placeholder_none.sv */
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* src/oamd_reg_select.sv */
// Register-operand selector: maps a 3-bit register code, the size flag
// and the data-operation width to a register index, width and byte half.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module oamd_reg_select
(
   input  wire logic               code_i,
   input  wire logic [2:0]         code_bits_i,
   input  wire logic               size_flag_i,
   input  wire logic               op32_i,
   output oamd_pkg::oamd_width_t   width_o,
   output logic [2:0]              reg_idx_o,
   output logic                    high_byte_o
);

   // ------------------------------------------------------------
   // Code decode
   // ------------------------------------------------------------
   // The same table serves the register field and the selector
   always_comb
   begin
      width_o     = oamd_pkg::OAMD_W_BYTE;
      reg_idx_o   = code_bits_i;
      high_byte_o = 1'b0;
      if (size_flag_i)
      begin
         // Full register n at the data-operation width
         width_o = op32_i ? oamd_pkg::OAMD_W_DWORD
                          : oamd_pkg::OAMD_W_WORD;
      end
      else if (code_bits_i >= oamd_pkg::BYTE_HIGH_FIRST)
      begin
         // Codes 4-7 are the upper bytes of registers 0-3
         reg_idx_o   = {1'b0, code_bits_i[1:0]};
         high_byte_o = 1'b1;
      end
      else
      begin
         reg_idx_o = {1'b0, code_bits_i[1:0]};
      end
   end

   // Marker input kept only so both instances read alike
   logic unused_code;
   assign unused_code = code_i;

endmodule

`default_nettype wire

/* testbench/oamd_assertions.sv */
// Concurrent checks on the decoder's top-level ports.
// Assumes one clock and outputs that load one edge after valid_i.
`timescale 1ns/1ps
`default_nettype none

module oamd_checker
(
   input wire logic        clk_i,
   input wire logic        arst_n_i,
   input wire logic        valid_i,
   input wire logic        addr32_i,
   input wire logic        size_flag_i,
   input wire logic        dir_flag_i,
   input wire logic [1:0]  imm_size_i,
   input wire logic [7:0]  specifier_i,
   input wire logic [7:0]  scale_byte_i,
   input wire logic [31:0] offset_i,
   input wire logic [31:0] imm_i,
   input wire logic        sib_expected_o,
   input wire logic        mem_operand_o,
   input wire logic [31:0] ea_offset_o,
   input wire logic        stack_segment_o,
   input wire logic [1:0]  offset_kind_o,
   input wire logic        index_used_o,
   input wire logic [2:0]  fld_reg_idx_o,
   input wire logic        fld_high_o,
   input wire logic        dst_is_field_o,
   input wire logic        src_is_field_o,
   input wire logic [31:0] imm_value_o
);
   // Reset voids any check still in flight
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);

   // Field views of the fetched bytes
   wire logic [1:0] form = specifier_i[7:6];
   wire logic [2:0] sel  = specifier_i[2:0];
   wire logic       sib  = addr32_i && sel == 3'h4 && form != 2'h3;

   a_sib_detect: assert property (valid_i |=>
      sib_expected_o == $past(sib)) else $error("scale byte flag wrong");
   a_mem_form: assert property (valid_i |=>
      mem_operand_o == ($past(form) != 2'h3)) else $error("memory flag wrong");
   a_bare_long: assert property (
      valid_i && addr32_i && form == 2'h0 && sel == 3'h5 |=> !stack_segment_o
      && offset_kind_o == 2'h2 && ea_offset_o == $past(offset_i))
      else $error("bare long offset wrong");
   a_short_kind: assert property (
      valid_i && addr32_i && form == 2'h1 |=> offset_kind_o == 2'h1)
      else $error("short offset kind wrong");
   a_stack_base: assert property (
      valid_i && sib && scale_byte_i[2:0] == 3'h4 |=> stack_segment_o)
      else $error("stack pointer base not in stack segment");
   a_no_index: assert property (
      valid_i && sib && scale_byte_i[5:3] == 3'h4 |=> !index_used_o)
      else $error("absent index still used");
   a_dir_roles: assert property (valid_i |=>
      dst_is_field_o == $past(dir_flag_i) && src_is_field_o == !dst_is_field_o)
      else $error("operand roles wrong");
   a_wide_imm: assert property (
      valid_i && imm_size_i == 2'h2 |=> imm_value_o == $past(imm_i))
      else $error("wide immediate altered");
   a_byte_field: assert property (valid_i && !size_flag_i |=>
      fld_reg_idx_o == {1'b0, $past(specifier_i[4:3])}
      && fld_high_o == $past(specifier_i[5])) else $error("byte register map wrong");
endmodule

bind oamd_operand_addr_decoder oamd_checker u_chk
(
   .clk_i, .arst_n_i, .valid_i, .addr32_i, .size_flag_i, .dir_flag_i,
   .imm_size_i, .specifier_i, .scale_byte_i, .offset_i, .imm_i,
   .sib_expected_o, .mem_operand_o, .ea_offset_o, .stack_segment_o,
   .offset_kind_o, .index_used_o, .fld_reg_idx_o, .fld_high_o,
   .dst_is_field_o, .src_is_field_o, .imm_value_o
);

`default_nettype wire

/* testbench/oamd_gpr_model.sv */
// Register-file stand-in that feeds general register values to the decoder.
// Assumes the decoder reads all eight registers as one flat 256-bit bus.
`timescale 1ns/1ps
`default_nettype none

module oamd_gpr_model
#(
   parameter logic [31:0] SEED = 32'h9e37_79b9
)
(
   output logic [255:0] gpr_o
);
   // ---------------------------------------------------------------
   // Register contents
   // ---------------------------------------------------------------
   // Distinct large values, so that swapped terms show and sums wrap
   always_comb
   begin
      for (int n = 0; n < 8; n++)
         gpr_o[n*32 +: 32] = SEED * 32'(n + 1);
   end
endmodule

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the operand and addressing-mode decoder.
// Assumes registered outputs that load one edge after valid_i.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
   $display("Error %s expected %h seen %h", nm, ex, got); n_mismatch++; end end

module tb;
   localparam logic [31:0] SEED  = 32'h9e37_79b9;
   localparam logic [31:0] OFS   = 32'h1234_56f0;
   localparam logic [31:0] SHORT = 32'hffff_fff0;
   int n_mismatch = 0;
   int n_compared = 0;
   logic clk_i = 1'b0, arst_n_i = 1'b0, valid_i = 1'b0, addr32_i = 1'b1;
   logic op32_i = 1'b1, size_flag_i = 1'b1, dir_flag_i = 1'b0, sign_ext_i = 1'b0;
   logic [1:0]   imm_size_i = 2'h2;
   logic [7:0]   specifier_i = 8'h00, scale_byte_i = 8'h00;
   logic [31:0]  offset_i = OFS, imm_i = 32'h0;
   logic [255:0] gpr_i;
   logic valid_o, sib_expected_o, mem_operand_o, addr_supported_o, stack_segment_o;
   logic base_used_o, index_used_o, sel_high_o, fld_high_o, dst_is_field_o, src_is_field_o;
   logic [1:0]   offset_kind_o, sel_width_o, fld_width_o;
   logic [2:0]   sel_reg_idx_o, fld_reg_idx_o;
   logic [31:0]  ea_offset_o, imm_value_o;

   // ---------------------------------------------------------------
   // Clock, partner and device
   // ---------------------------------------------------------------
   always #5 clk_i = ~clk_i;

   oamd_gpr_model #(.SEED(SEED)) u_gpr (.gpr_o(gpr_i));

   oamd_operand_addr_decoder uut
   (
      .clk_i, .arst_n_i, .valid_i, .addr32_i, .op32_i, .size_flag_i, .dir_flag_i,
      .sign_ext_i, .imm_size_i, .specifier_i, .scale_byte_i, .offset_i, .imm_i,
      .gpr_i, .valid_o, .sib_expected_o, .mem_operand_o, .addr_supported_o,
      .ea_offset_o, .stack_segment_o, .offset_kind_o, .base_used_o, .index_used_o,
      .sel_reg_idx_o, .sel_width_o, .sel_high_o, .fld_reg_idx_o, .fld_width_o,
      .fld_high_o, .dst_is_field_o, .src_is_field_o, .imm_value_o
   );

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // Own copy of the register contents, kept apart from the partner
   function automatic logic [31:0] gv(input int n);
      return SEED * 32'(n + 1);
   endfunction

   // One request; outputs are looked at once the loading edge has landed
   task automatic issue(input logic [7:0] spec, input logic [7:0] sb);
      @(posedge clk_i);
      #1;
      valid_i = 1'b1;
      specifier_i = spec;
      scale_byte_i = sb;
      @(posedge clk_i);
      #1;
      valid_i = 1'b0;
      `CHK("valid_o", 1'b1, valid_o)
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Every memory form without a scale byte; selector 100 left to t_sib
   task automatic t_no_sib();
      logic [31:0] ex;
      for (int f = 0; f < 3; f++)
         for (int s = 0; s < 8; s++)
         begin
            if (s == 4) continue;
            ex = (f == 0 && s == 5) ? OFS : gv(s) + (f == 1 ? SHORT : f == 2 ? OFS : 32'h0);
            issue({2'(f), 3'h2, 3'(s)}, 8'h00);
            `CHK("ea_plain", ex, ea_offset_o)
            `CHK("seg_plain", 1'(s == 5 && f != 0), stack_segment_o)
            `CHK("kind_plain", (f == 0 && s == 5) ? 2'h2 : 2'(f), offset_kind_o)
            `CHK("base_plain", 1'(f > 0 || s != 5), base_used_o)
         end
      // Narrow addressing is flagged, never decoded
      addr32_i = 1'b0;
      issue(8'h44, 8'h88);
      `CHK("supported", 1'b0, addr_supported_o)
      `CHK("ea_narrow", 32'h0000_0000, ea_offset_o)
      `CHK("base_narrow", 1'b0, base_used_o)
      addr32_i = 1'b1;
   endtask

   // All bases and indexes under each memory form; all scales except with index 100 (scale 0 only)
   task automatic t_sib();
      logic [31:0] ex;
      for (int f = 0; f < 3; f++)
         for (int b = 0; b < 8; b++)
            for (int x = 0; x < 8; x++)
               for (int ss = 0; ss < 4; ss++)
               begin
                  if (x == 4 && ss != 0) continue;
                  ex = (f == 0 && b == 5) ? OFS : gv(b);
                  ex += (x == 4) ? 32'h0 : gv(x) << ss;
                  ex += (f == 1) ? SHORT : (f == 2) ? OFS : 32'h0;
                  issue({2'(f), 3'h7, 3'h4}, {2'(ss), 3'(x), 3'(b)});
                  `CHK("ea_sib", ex, ea_offset_o)
                  `CHK("seg_sib", 1'(b == 4 || b == 5 && f > 0), stack_segment_o)
                  `CHK("sib_flag", 1'b1, sib_expected_o)
                  `CHK("idx_used", 1'(x != 4), index_used_o)
                  `CHK("base_sib", 1'(f > 0 || b != 5), base_used_o)
               end
   endtask

   // Register form, both data widths, both size flags, both directions
   task automatic t_regs();
      logic [1:0] wd;
      for (int o = 0; o < 2; o++)
         for (int w = 0; w < 2; w++)
            for (int c = 0; c < 8; c++)
            begin
               op32_i = 1'(o);
               size_flag_i = 1'(w);
               dir_flag_i = 1'(c);
               wd = (w == 0) ? 2'h0 : (o == 1) ? 2'h2 : 2'h1;
               issue({2'h3, 3'(7 - c), 3'(c)}, 8'h00);
               `CHK("mem_op", 1'b0, mem_operand_o)
               `CHK("ea_reg", 32'h0, ea_offset_o)
               `CHK("sel_idx", (w == 1) ? 3'(c) : 3'(c % 4), sel_reg_idx_o)
               `CHK("sel_hi", 1'(w == 0 && c >= 4), sel_high_o)
               `CHK("sel_w", wd, sel_width_o)
               `CHK("fld_idx", w ? 3'(7 - c) : 3'(3 - c % 4), fld_reg_idx_o)
               `CHK("fld_w", wd, fld_width_o)
               `CHK("dst_fld", 1'(c % 2), dst_is_field_o)
               `CHK("src_fld", 1'(1 - c % 2), src_is_field_o)
            end
   endtask

   // Every immediate size against sign-extend bit and destination width
   task automatic t_imm();
      logic [31:0] ex;
      imm_i = 32'h89ab_cd85;
      for (int z = 0; z < 4; z++)
         for (int s = 0; s < 2; s++)
            for (int w = 0; w < 4; w++)
            begin
               imm_size_i = 2'(z);
               sign_ext_i = 1'(s);
               size_flag_i = 1'(w);
               op32_i = 1'(w / 2);
               case (z)
                  0: ex = (s == 1 && w % 2 == 1) ? (w >= 2 ? 32'hffff_ff85 : 32'hff85) : 32'h85;
                  1: ex = 32'h0000_cd85;
                  2: ex = 32'h89ab_cd85;
                  default: ex = 32'h0;
               endcase
               issue(8'hc0, 8'h00);
               `CHK("imm", ex, imm_value_o)
            end
   endtask

   // ---------------------------------------------------------------
   // Main sequence and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge clk_i);
      #1;
      `CHK("valid_rst", 1'b0, valid_o)
      arst_n_i = 1'b1;
      t_no_sib();
      t_sib();
      t_regs();
      t_imm();
      give_verdict();
   end

   // Whole run needs about 1600 cycles; nearly four times that means a hang
   initial
   begin
      #60000;
      n_mismatch++;
      give_verdict();
   end
endmodule

`default_nettype wire
